// File: shared/srl_pkg.sv
// package for the status relay output logic
// assumes one 100 MHz clock domain and plain control ports
package srl_pkg;

    // ==========================================================
    // operating modes and measuring modes
    // ==========================================================
    typedef enum logic [1:0] {
        SRL_OP_OFF,                                   // power off
        SRL_OP_START,                                 // start-up
        SRL_OP_MEAS,                                  // measuring
        SRL_OP_SLEEP                                  // sleep (fault)
    } srl_opmode_t;

    typedef enum logic [1:0] {
        SRL_MM_NORMAL,
        SRL_MM_ZERO,
        SRL_MM_SPAN,
        SRL_MM_MAINT
    } srl_measmode_t;

    // relay-3 software function
    typedef enum logic [1:0] {
        SRL_R3_NORMAL,
        SRL_R3_INVERTED,
        SRL_R3_MAINT
    } srl_r3cfg_t;

    // ==========================================================
    // constants
    // ==========================================================
    localparam int          SRL_CONC_W      = 32;      // signed concentration width
    localparam int          SRL_NGAS        = 3;       // gas lines
    localparam int          SRL_MA_W        = 16;      // current code width, uA units
    localparam logic [15:0] SRL_MA_ZERO     = 16'h0000; // 0 mA
    localparam logic [15:0] SRL_MA_ERROR    = 16'h07D0; // 2 mA = 2000 uA
    localparam int          SRL_HOLD_FACTOR = 3;       // hold = 3 x averaging time
    localparam int          SRL_CLK_MHZ     = 100;     // clock rate
    localparam int          SRL_AVG_W       = 32;      // averaging time width, in cycles

    // status flags carried together
    typedef struct packed {
        logic warn;                                   // possible measurement problem
        logic err;                                    // measurement failure
    } srl_status_t;

    // relay drive bundle, 1 = contact conducting
    typedef struct packed {
        logic error;
        logic warning;
        logic relay3;
    } srl_relays_t;

endpackage : srl_pkg

// File: hw/srl_status_relay_output.sv
// status relay and current-loop output logic
// assumes inputs synchronous to clk_i; alarm levels in same units as concentration
`timescale 1ns/1ps
`default_nettype none

module srl_status_relay_output
    import srl_pkg::*;
#(
    parameter int NGAS   = SRL_NGAS,
    parameter int CONC_W = SRL_CONC_W
) (
    input  wire logic                           clk_i,
    input  wire logic                           rst_b_i,
    input  wire logic [1:0]                     opmode_i,        // srl_opmode_t code
    input  wire logic                           span_contact_i,  // first contact closed
    input  wire logic                           zero_contact_i,  // second contact closed
    input  wire logic [NGAS-1:0][CONC_W-1:0]    gas_conc_i,      // signed concentrations
    input  wire logic                           conc_valid_i,    // new valid measurement
    input  wire logic [SRL_MA_W-1:0]            conc_ma_i,       // loop code of gas_conc
    input  wire logic [NGAS-1:0][CONC_W-1:0]    alarm_level_i,   // signed alarm levels
    input  wire logic [CONC_W-1:0]              maint_level_i,   // maintenance code (-1E20)
    input  wire srl_status_t                    status_i,
    input  wire logic                           error_option2_i, // 0 option one, 1 option two
    input  wire logic [SRL_AVG_W-1:0]           avg_cycles_i,    // averaging time in cycles
    input  wire logic                           relay3_polarity_switch_i, // 1 = swapped
    output logic                                relay_error_o,
    output logic                                relay_warning_o,
    output logic                                relay3_o,
    output logic [SRL_MA_W-1:0]                 current_loop_output_o,
    output logic [SRL_MA_W-1:0]                 digital_out_o,   // digital concentration
    output logic                                warn_msg_o,      // warning message on
    output logic                                err_msg_o,       // error message on
    output srl_measmode_t                       meas_mode_o
);

    // ==========================================================
    // measuring mode decode and relay-3 configuration
    // ==========================================================
    srl_measmode_t meas_mode;
    srl_opmode_t   op;
    srl_r3cfg_t    r3cfg;
    logic          alarm;                 // any gas above its absolute level, except in maintenance config
    logic [NGAS-1:0] gas_over;            // per-gas compare

    assign op = srl_opmode_t'(opmode_i);

    // contacts to mode
    always_comb begin
        case ({span_contact_i, zero_contact_i})
            2'b00:   meas_mode = SRL_MM_NORMAL;
            2'b01:   meas_mode = SRL_MM_ZERO;
            2'b10:   meas_mode = SRL_MM_SPAN;
            default: meas_mode = SRL_MM_MAINT;
        endcase
    end

    // per-gas alarm compare against absolute level
    generate
        for (genvar g = 0; g < NGAS; g++) begin : g_alarm
            logic signed [CONC_W-1:0] lvl;
            logic signed [CONC_W-1:0] abs_lvl;
            assign lvl      = $signed(alarm_level_i[g]);
            assign abs_lvl  = lvl[CONC_W-1] ? -lvl : lvl;
            assign gas_over[g] = $signed(gas_conc_i[g]) > abs_lvl;
        end
    endgenerate

    // configuration from alarm levels, exactly one function
    always_comb begin
        logic all_maint;
        all_maint = 1'b1;
        for (int g = 0; g < NGAS; g++) begin
            if (alarm_level_i[g] != maint_level_i) begin
                all_maint = 1'b0;
            end
        end
        if (all_maint) begin
            r3cfg = SRL_R3_MAINT;
        end else if (alarm_level_i[0][CONC_W-1]) begin
            r3cfg = SRL_R3_INVERTED;
        end else begin
            r3cfg = SRL_R3_NORMAL;
        end
    end

    assign alarm = (r3cfg != SRL_R3_MAINT) && (|gas_over);

    // ==========================================================
    // relay 3 nominal state and sleep latch
    // ==========================================================
    logic r3_nominal;                     // state before polarity switch
    logic r3_latch;                       // latched state in sleep
    logic next_r3_latch;
    logic was_sleep;
    logic next_was_sleep;

    // nominal relay 3 from config and mode, 1 = conducting
    always_comb begin
        case (r3cfg)
            SRL_R3_NORMAL:   r3_nominal = !alarm;
            SRL_R3_INVERTED: r3_nominal = alarm;
            SRL_R3_MAINT:    r3_nominal = (meas_mode != SRL_MM_NORMAL);
            default:         r3_nominal = 1'b0;
        endcase
    end

    // follow the nominal state while awake, freeze it from the sleep entry edge on
    // a contact change sampled at that same edge already counts as a request made in sleep
    always_comb begin
        next_was_sleep = (op == SRL_OP_SLEEP);
        next_r3_latch  = r3_nominal;                      // awake: track the mode
        if (op == SRL_OP_SLEEP) begin
            next_r3_latch = r3_latch;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r3_latch  <= 1'b0;
            was_sleep <= 1'b0;
        end else begin
            r3_latch  <= next_r3_latch;
            was_sleep <= next_was_sleep;
        end
    end

    // ==========================================================
    // last valid value and error hold timer
    // ==========================================================
    logic [SRL_MA_W-1:0]  last_ma;        // last valid concentration code
    logic [SRL_MA_W-1:0]  next_last_ma;
    logic [SRL_AVG_W+1:0] hold_cnt;       // cycles held after error
    logic [SRL_AVG_W+1:0] next_hold_cnt;
    logic [SRL_AVG_W+1:0] hold_len;
    logic                 hold_done;

    assign hold_len  = (SRL_AVG_W+2)'(SRL_HOLD_FACTOR) * {2'b00, avg_cycles_i};
    assign hold_done = (hold_cnt >= hold_len);

    // track last good value, run timer while error stands
    always_comb begin
        next_last_ma  = last_ma;
        next_hold_cnt = '0;
        if (conc_valid_i && !status_i.err && op == SRL_OP_MEAS) begin
            next_last_ma = conc_ma_i;
        end
        if (status_i.err && op == SRL_OP_MEAS) begin
            next_hold_cnt = hold_done ? hold_cnt : hold_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            last_ma  <= SRL_MA_ZERO;
            hold_cnt <= '0;
        end else begin
            last_ma  <= next_last_ma;
            hold_cnt <= next_hold_cnt;
        end
    end

    // ==========================================================
    // output selection per operating mode
    // ==========================================================
    srl_relays_t          rel_nom;        // nominal relay states
    srl_relays_t          next_rel;
    logic [SRL_MA_W-1:0]  next_loop;
    logic [SRL_MA_W-1:0]  next_dig;
    srl_relays_t          rel_q;

    always_comb begin
        rel_nom   = '0;
        next_loop = SRL_MA_ZERO;
        next_dig  = digital_out_o;
        case (op)
            SRL_OP_OFF: begin
                rel_nom   = '0;
                next_loop = SRL_MA_ZERO;
            end
            SRL_OP_START: begin
                rel_nom.error   = 1'b0;
                rel_nom.warning = 1'b1;
                rel_nom.relay3  = (r3cfg == SRL_R3_MAINT) ? 1'b0 : 1'b1;
                next_loop       = SRL_MA_ZERO;
                next_dig        = SRL_MA_ZERO;
            end
            SRL_OP_MEAS: begin
                // same status mapping in every measuring mode
                rel_nom.error   = !status_i.err;
                rel_nom.warning = !status_i.err && !status_i.warn;
                rel_nom.relay3  = r3_nominal;
                if (!status_i.err) begin
                    next_loop = conc_ma_i;
                    next_dig  = conc_ma_i;
                end else if (!error_option2_i && hold_done) begin
                    next_loop = SRL_MA_ERROR;
                    next_dig  = last_ma;
                end else begin
                    next_loop = last_ma;
                    next_dig  = last_ma;
                end
            end
            default: begin
                rel_nom.error   = 1'b0;
                rel_nom.warning = 1'b0;
                rel_nom.relay3  = (r3cfg == SRL_R3_MAINT) ? r3_latch : 1'b1;
                next_loop       = SRL_MA_ERROR;
                next_dig        = last_ma;
            end
        endcase
        next_rel        = rel_nom;
        next_rel.relay3 = rel_nom.relay3 ^ relay3_polarity_switch_i;
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rel_q                 <= '0;
            current_loop_output_o <= SRL_MA_ZERO;
            digital_out_o         <= SRL_MA_ZERO;
        end else begin
            rel_q                 <= next_rel;
            current_loop_output_o <= next_loop;
            digital_out_o         <= next_dig;
        end
    end

    // relay pins, 1 = conducting
    assign relay_error_o   = rel_q.error;
    assign relay_warning_o = rel_q.warning;
    assign relay3_o        = rel_q.relay3;
    assign warn_msg_o      = (op == SRL_OP_MEAS) && status_i.warn;
    assign err_msg_o       = (op == SRL_OP_MEAS) && status_i.err;
    assign meas_mode_o     = meas_mode;

    // ==========================================================
    // assertions
    // ==========================================================
    sequence s_err_meas;
        op == SRL_OP_MEAS && status_i.err;
    endsequence

    property p_err_relay;
        @(posedge clk_i) disable iff (!rst_b_i)
        s_err_meas |=> !relay_error_o;
    endproperty
    a_err_relay: assert property (p_err_relay) else $error("error relay not off");

    property p_warn_relay;
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == SRL_OP_MEAS && status_i.warn) |=> !relay_warning_o;
    endproperty
    a_warn_relay: assert property (p_warn_relay) else $error("warning relay not off");

    property p_ok_relays;
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == SRL_OP_MEAS && !status_i.err && !status_i.warn) |=> (relay_error_o && relay_warning_o);
    endproperty
    a_ok_relays: assert property (p_ok_relays) else $error("relays wrong in good state");

    property p_opt2_hold;
        @(posedge clk_i) disable iff (!rst_b_i)
        (s_err_meas and error_option2_i) |=> current_loop_output_o == $past(last_ma);
    endproperty
    a_opt2_hold: assert property (p_opt2_hold) else $error("option two not holding");

    property p_opt1_force;
        @(posedge clk_i) disable iff (!rst_b_i)
        (s_err_meas and !error_option2_i && hold_done) |=> current_loop_output_o == SRL_MA_ERROR;
    endproperty
    a_opt1_force: assert property (p_opt1_force) else $error("option one not at 2 mA");

    property p_sleep_out;
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == SRL_OP_SLEEP) |=> (!relay_error_o && !relay_warning_o && current_loop_output_o == SRL_MA_ERROR);
    endproperty
    a_sleep_out: assert property (p_sleep_out) else $error("sleep outputs wrong");

    property p_off_out;
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == SRL_OP_OFF && !relay3_polarity_switch_i) |=> (rel_q == '0 && current_loop_output_o == SRL_MA_ZERO);
    endproperty
    a_off_out: assert property (p_off_out) else $error("power off outputs wrong");

    property p_sleep_latch;
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == SRL_OP_SLEEP && was_sleep && $stable(relay3_polarity_switch_i) && r3cfg == SRL_R3_MAINT
            && $past(op) == SRL_OP_SLEEP) |=> $stable(relay3_o);
    endproperty
    a_sleep_latch: assert property (p_sleep_latch) else $error("relay 3 moved in sleep");

    property p_maint_r3;
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == SRL_OP_MEAS && r3cfg == SRL_R3_MAINT)
            |=> relay3_o == (($past(meas_mode) != SRL_MM_NORMAL) ^ $past(relay3_polarity_switch_i));
    endproperty
    a_maint_r3: assert property (p_maint_r3) else $error("maintenance relay 3 wrong");

    // start-up pattern does not depend on the polarity switch for relays 1 and 2
    property p_start_out;
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == SRL_OP_START) |=> (!relay_error_o && relay_warning_o && current_loop_output_o == SRL_MA_ZERO);
    endproperty
    a_start_out: assert property (p_start_out) else $error("start-up outputs wrong");

    // before the hold time runs out the loop still shows the last good value
    property p_opt1_hold;
        @(posedge clk_i) disable iff (!rst_b_i)
        (s_err_meas and !error_option2_i && !hold_done) |=> current_loop_output_o == $past(last_ma);
    endproperty
    a_opt1_hold: assert property (p_opt1_hold) else $error("option one not holding");

    // the switch swaps relay 3 even while powered off
    property p_off_swap;
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == SRL_OP_OFF && relay3_polarity_switch_i) |=> relay3_o;
    endproperty
    a_off_swap: assert property (p_off_swap) else $error("relay 3 not swapped at power off");

    // inverted gas alarm conducts exactly while an alarm stands
    property p_inv_r3;
        @(posedge clk_i) disable iff (!rst_b_i)
        (op == SRL_OP_MEAS && r3cfg == SRL_R3_INVERTED && !relay3_polarity_switch_i) |=> relay3_o == $past(alarm);
    endproperty
    a_inv_r3: assert property (p_inv_r3) else $error("inverted relay 3 wrong");

endmodule : srl_status_relay_output

`default_nettype wire

// File: verification/srl_plant_model.sv
// plant-side model: contact pair driven by the plant controller to pick a measuring mode
// assumes the bench asks for a mode as an srl_measmode_t level
`timescale 1ns/1ps
`default_nettype none

module srl_plant_model
    import srl_pkg::*;
(
    input  wire srl_measmode_t mode_req_i,     // mode the plant wants
    output logic               span_contact_o, // first contact closed
    output logic               zero_contact_o  // second contact closed
);
    // ==========================================================
    // contact encoding
    // ==========================================================
    // span alone closes the first, zero alone the second, maintenance both
    assign span_contact_o = (mode_req_i == SRL_MM_SPAN) || (mode_req_i == SRL_MM_MAINT);
    assign zero_contact_o = (mode_req_i == SRL_MM_ZERO) || (mode_req_i == SRL_MM_MAINT);
endmodule : srl_plant_model

`default_nettype wire

// File: verification/srl_status_relay_output_bench.sv
// bench for the status relay output logic, one task per scenario
// assumes the plant model drives the mode contacts
`timescale 1ns/1ps
`default_nettype none

module srl_status_relay_output_bench;
    import srl_pkg::*;
    // ==========================================================
    // stimulus and observed signals
    // ==========================================================
    localparam logic [31:0] LVL   = 32'h0000_03E8; // alarm level 1000
    localparam logic [31:0] NLVL  = 32'hFFFF_FC18; // alarm level -1000
    localparam logic [31:0] LOW   = 32'h0000_0064; // concentration 100
    localparam logic [31:0] HIGH  = 32'h0000_05DC; // concentration 1500
    localparam logic [31:0] MAINT = 32'h8000_0001; // stands for -1E20
    logic                   clk_i       = 1'b0;
    logic                   rst_b_i     = 1'b0;
    logic [1:0]             opmode      = 2'h0;
    srl_measmode_t          mode_req    = SRL_MM_NORMAL;
    logic [2:0][31:0]       conc        = {LOW, LOW, LOW};
    logic [2:0][31:0]       lvl         = {LVL, LVL, LVL};
    logic                   conc_valid  = 1'b1;
    logic [15:0]            conc_ma     = 16'h0100;
    srl_status_t            status      = '0;
    logic                   opt2        = 1'b0;
    logic                   pol_sw      = 1'b0;
    logic [31:0]            avg         = 32'h0000_0004; // averaging time in cycles
    logic                   span_c;       // contact from plant
    logic                   zero_c;       // contact from plant
    logic                   r_err;        // error relay
    logic                   r_warn;       // warning relay
    logic                   r3;           // relay 3
    logic [15:0]            loop_ma;      // current loop code
    logic [15:0]            dig;          // digital output
    logic                   warn_msg;     // warning message
    logic                   err_msg;      // error message
    srl_measmode_t          mm;           // decoded mode
    int                     failures = 0; // mismatches
    int                     compares = 0; // comparisons
    int                     cycles   = 0; // elapsed clocks

    // ==========================================================
    // clock, timeout, instances
    // ==========================================================
    always #5 clk_i = ~clk_i;
    // run should end well inside 3000 clocks
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            failures++;
            stop_test();
        end
    end

    srl_plant_model srl_plant_model_inst (
        .mode_req_i(mode_req), .span_contact_o(span_c), .zero_contact_o(zero_c));

    srl_status_relay_output srl_status_relay_output_inst (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .opmode_i(opmode),
        .span_contact_i(span_c), .zero_contact_i(zero_c), .gas_conc_i(conc),
        .conc_valid_i(conc_valid), .conc_ma_i(conc_ma), .alarm_level_i(lvl),
        .maint_level_i(MAINT), .status_i(status), .error_option2_i(opt2),
        .avg_cycles_i(avg), .relay3_polarity_switch_i(pol_sw),
        .relay_error_o(r_err), .relay_warning_o(r_warn), .relay3_o(r3),
        .current_loop_output_o(loop_ma), .digital_out_o(dig), .warn_msg_o(warn_msg),
        .err_msg_o(err_msg), .meas_mode_o(mm));

    // ==========================================================
    // helpers
    // ==========================================================
    // wait n edges, then step off the edge to drive or sample
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step

    task automatic chk1(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk16

    task automatic stop_test();
        $display("failures %0d compares %0d", failures, compares);
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // ==========================================================
    // scenarios
    // ==========================================================
    // power off in both switch positions, then start-up pattern with gas-alarm config
    task automatic t_start();
        step(2);
        chk1("off error", 1'b0, r_err);
        chk1("off warning", 1'b0, r_warn);
        chk1("off relay3", 1'b0, r3);
        chk16("off loop", 16'h0000, loop_ma);
        pol_sw = 1'b1;
        step(2);
        chk1("off relay3 swapped", 1'b1, r3);
        pol_sw = 1'b0;
        opmode = 2'h1;
        step(2);
        chk1("start error", 1'b0, r_err);
        chk1("start warning", 1'b1, r_warn);
        chk1("start relay3", 1'b1, r3);
        chk16("start loop", 16'h0000, loop_ma);
        chk16("start digital", 16'h0000, dig);
        opmode = 2'h2;
    endtask : t_start

    // every contact pair, no alarm, status good
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            mode_req = srl_measmode_t'(m);
            step(2);
            chk16("mode", 16'(m), 16'(mm));
            chk1("mode error", 1'b1, r_err);
            chk1("mode warning", 1'b1, r_warn);
            chk1("mode relay3", 1'b1, r3);
        end
    endtask : t_modes

    // normal then inverted gas alarm, plus polarity switch
    task automatic t_alarm();
        mode_req = SRL_MM_NORMAL;
        conc[1] = HIGH;
        lvl[1] = NLVL;
        step(2);
        chk1("alarm relay3", 1'b0, r3);
        lvl = {LVL, LVL, NLVL};
        conc = {LOW, LOW, LOW};
        step(2);
        chk1("inv quiet relay3", 1'b0, r3);
        conc[2] = HIGH;
        mode_req = SRL_MM_ZERO;
        step(2);
        chk1("inv alarm relay3", 1'b1, r3);
        pol_sw = 1'b1;
        step(2);
        chk1("swapped relay3", 1'b0, r3);
        pol_sw = 1'b0;
        conc = {LOW, LOW, LOW};
        lvl = {MAINT, MAINT, MAINT};
        mode_req = SRL_MM_NORMAL;
    endtask : t_alarm

    // maintenance config, both modes, both switch positions
    task automatic t_maint();
        for (int i = 0; i < 4; i++) begin
            pol_sw = i[1];
            mode_req = i[0] ? SRL_MM_SPAN : SRL_MM_NORMAL;
            step(2);
            chk1("maint relay3", i[0] ^ i[1], r3);
        end
        pol_sw = 1'b0;
    endtask : t_maint

    // warning, then error with either loop option; hold edges checked at 3 x averaging time
    task automatic t_fault(input logic opt, input logic [31:0] avg_t);
        opt2 = opt;
        avg = avg_t;
        mode_req = SRL_MM_NORMAL;
        conc_ma = 16'h1234;
        status.warn = 1'b1;
        step(2);
        chk1("warning relay", 1'b0, r_warn);
        chk1("warning msg", 1'b1, warn_msg);
        chk1("error kept", 1'b1, r_err);
        chk16("loop live", 16'h1234, loop_ma);
        chk16("digital live", 16'h1234, dig);
        status = '{warn: 1'b0, err: 1'b1};
        conc_ma = 16'h5555;
        step(1);
        chk1("error relay", 1'b0, r_err);
        chk1("error msg", 1'b1, err_msg);
        step(SRL_HOLD_FACTOR * avg_t - 1);
        chk16("loop held", 16'h1234, loop_ma);
        step(1);
        chk16("loop late", opt ? 16'h1234 : SRL_MA_ERROR, loop_ma);
        chk16("digital held", 16'h1234, dig);
        step(8);
        chk16("loop kept", opt ? 16'h1234 : SRL_MA_ERROR, loop_ma);
        status.err = 1'b0;
        step(2);
        chk1("error back", 1'b1, r_err);
        chk16("loop live again", 16'h5555, loop_ma);
    endtask : t_fault

    // sleep latches relay 3 against later contact changes
    task automatic t_sleep();
        logic [15:0] held;
        for (int i = 0; i < 2; i++) begin
            mode_req = i[0] ? SRL_MM_ZERO : SRL_MM_NORMAL;
            step(2);
            held = conc_ma;
            opmode = 2'h3;
            // a mode request and a new reading land with the sleep entry
            mode_req = i[0] ? SRL_MM_NORMAL : SRL_MM_MAINT;
            conc_ma = ~held;
            step(2);
            chk1("sleep relay3", i[0], r3);
            chk1("sleep error", 1'b0, r_err);
            chk1("sleep warning", 1'b0, r_warn);
            chk16("sleep loop", SRL_MA_ERROR, loop_ma);
            chk16("sleep digital", held, dig);
            mode_req = i[0] ? SRL_MM_SPAN : SRL_MM_NORMAL;
            step(3);
            chk1("sleep relay3 kept", i[0], r3);
            opmode = 2'h2;
        end
    endtask : t_sleep

    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        repeat (12) @(posedge clk_i);
        #1;
        rst_b_i = 1'b1;
        t_start();
        t_modes();
        t_alarm();
        t_maint();
        t_fault(1'b0, 32'h0000_0004);
        t_fault(1'b1, 32'h0000_0004);
        t_fault(1'b0, 32'h0000_0007);
        t_sleep();
        stop_test();
    end
endmodule : srl_status_relay_output_bench

`default_nettype wire
